/* hw/isc_collector.sv */
// interrupt status collector: sticky event flags, enable mask, apb slave
// ==========================================================
// Notes on behaviour
// - 32-bit status word at 0x58; writing one to a flag clears it.
// - bit 31 sets while the software event enable bit is high.
// - bit 25 sets when stop is requested and the transmitter has halted.
// - bit 24 sets once the receive engine has halted.
// - bit 23 sets when drop counter steps from 7fffffff to 80000000.
// - bit 21 sets when a completion-marked buffer is fully loaded.
// - bit 20 sets when the programmed receive dma count has moved out.
// - bit 19 sets when the timer steps from zero to ffff.
// - bit 18 shows the pending transceiver event live; writes ignored.
// - bit 17 sets on power events, independent of wake pin; w1c.
// - power event bypasses the interrupt hold-off interval.
// - bit 16 sets when the transmit status fifo overflows.
// - bit 15 sets when a frame over 2048 bytes is received.
// - bit 14 sets on a receive engine error.
// - bit 13 sets on a transmit engine error.
// - bit 10 sets on a data fifo write attempted while full.
// - bit 9 sets while free transmit space exceeds the level.
// - bit 8 on transmit status full, bit 4 on receive status full.
// - bit 7 and bit 3 set when status fifo use passes its level.
// - bit 6 sets each time a receive frame is dropped.
// - bits 2-0 follow the three pin event detectors; w1c.
// - flags latch regardless of the enable mask.
// - master line is high while any enabled flag is active.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module isc_collector (
  input wire logic clk,
  input wire logic rstn,
  input wire isc_pkg::isc_apb_req_t apb_req,
  output isc_pkg::isc_apb_rsp_t apb_rsp,
  input wire isc_pkg::isc_evt_t evt,
  input wire logic hold_off_active,
  input wire logic enter_low_power,
  output logic low_power,
  output logic master_line,
  output logic irq_request
);

  // ==========================================================
  // state
  isc_pkg::isc_state_t state_reg;
  isc_pkg::isc_state_t state_next;

  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic sts_wr;
  logic en_wr;
  logic bt_wr;
  logic mapped;
  logic [31:0] set_vec;
  logic [31:0] flag_view;
  logic [31:0] clr_vec;
  logic [31:0] active_vec;
  logic [31:0] state_word;
  logic [31:0] read_word;

  // ==========================================================
  // bus decode
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_access = access_phase & apb_req.pwrite;
  assign sts_wr = wr_access & (apb_req.paddr == isc_pkg::OFF_STS);
  assign en_wr = wr_access & (apb_req.paddr == isc_pkg::OFF_EN);
  assign bt_wr = wr_access & (apb_req.paddr == isc_pkg::OFF_BT);
  assign mapped = (apb_req.paddr == isc_pkg::OFF_STATE) |
                  (apb_req.paddr == isc_pkg::OFF_STS) |
                  (apb_req.paddr == isc_pkg::OFF_EN) |
                  (apb_req.paddr == isc_pkg::OFF_BT);

  // ==========================================================
  // event sources
  always_comb begin
    set_vec = isc_pkg::WORD_ZERO;
    set_vec[isc_pkg::B_SW] = state_reg.enable[isc_pkg::B_SW];
    set_vec[isc_pkg::B_TXSTOP] = evt.tx_stop_request & evt.tx_halted;
    set_vec[isc_pkg::B_RXSTOP] = evt.rx_halted;
    set_vec[isc_pkg::B_DROPMID] = (state_reg.prev_drop == isc_pkg::DROP_BEFORE_MID) &
                                  (evt.drop_count == isc_pkg::DROP_AFTER_MID);
    set_vec[isc_pkg::B_TXDONE] = evt.tx_buffer_complete;
    set_vec[isc_pkg::B_RXDMA] = evt.rx_dma_done;
    set_vec[isc_pkg::B_TIMER] = (state_reg.prev_timer == isc_pkg::TIMER_ZERO) &
                                (evt.timer_count == isc_pkg::TIMER_WRAP);
    set_vec[isc_pkg::B_WAKE] = evt.power_wake_event;
    set_vec[isc_pkg::B_TXSOVF] = evt.tx_status_overflow;
    set_vec[isc_pkg::B_OVERSIZE] = evt.oversize_rx_frame;
    set_vec[isc_pkg::B_RXERR] = evt.receive_error;
    set_vec[isc_pkg::B_TXERR] = evt.transmit_error;
    set_vec[isc_pkg::B_TDOVR] = evt.tx_data_full & evt.tx_data_write;
    set_vec[isc_pkg::B_TDAVAIL] = evt.tx_free_blocks > evt.tx_avail_level;
    set_vec[isc_pkg::B_TSFULL] = evt.tx_status_full;
    set_vec[isc_pkg::B_RSFULL] = evt.rx_status_full;
    set_vec[isc_pkg::B_TSLEVEL] = evt.tx_status_used > evt.tx_status_level;
    set_vec[isc_pkg::B_RSLEVEL] = evt.rx_status_used > evt.rx_status_level;
    set_vec[isc_pkg::B_RXDROP] = evt.frame_dropped;
    set_vec[isc_pkg::B_PIN_HI:isc_pkg::B_PIN_LO] = evt.pin_events;
  end

  // phy bit is not stored, it mirrors the transceiver line
  always_comb begin
    flag_view = state_reg.flags & isc_pkg::STORED_MASK;
    flag_view[isc_pkg::B_PHY] = evt.transceiver_event;
  end

  // only ones clear, and never the phy mirror
  assign clr_vec = sts_wr ? (apb_req.pwdata & isc_pkg::STORED_MASK) : isc_pkg::WORD_ZERO;
  assign active_vec = flag_view & state_reg.enable;

  always_comb begin
    state_word = isc_pkg::WORD_ZERO;
    state_word[isc_pkg::STATE_SLEEP_BIT] = (state_reg.power == isc_pkg::ISC_ASLEEP);
    state_word[isc_pkg::STATE_MASTER_BIT] = state_reg.master;
  end

  always_comb begin
    read_word = isc_pkg::WORD_ZERO;
    unique case (apb_req.paddr)
      isc_pkg::OFF_STATE: read_word = state_word;
      isc_pkg::OFF_STS: read_word = flag_view;
      isc_pkg::OFF_EN: read_word = state_reg.enable;
      isc_pkg::OFF_BT: read_word = isc_pkg::BYTE_TEST_VALUE;
      default: read_word = isc_pkg::WORD_ZERO;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    // set after clear so a coincident event survives the write
    state_next.flags = ((state_reg.flags & ~clr_vec) | set_vec) &
                       isc_pkg::STORED_MASK;
    if (en_wr) begin
      state_next.enable = apb_req.pwdata & isc_pkg::IMPL_MASK;
    end
    state_next.prev_drop = evt.drop_count;
    state_next.prev_timer = evt.timer_count;
    unique case (state_reg.power)
      isc_pkg::ISC_AWAKE: begin
        if (enter_low_power) begin
          state_next.power = isc_pkg::ISC_ASLEEP;
        end
      end
      isc_pkg::ISC_ASLEEP: begin
        // power events and the wake pin do not end low power
        if (bt_wr) begin
          state_next.power = isc_pkg::ISC_AWAKE;
        end
      end
    endcase
    state_next.master = |active_vec;
    // hold-off gates everything except the power event
    state_next.irq = hold_off_active ? |(active_vec & isc_pkg::WAKE_MASK)
                                     : |active_vec;
    // read data is sampled in setup so prdata comes from a flop
    if (setup_phase) begin
      state_next.rdata = apb_req.pwrite ? isc_pkg::WORD_ZERO : read_word;
      state_next.slverr = ~mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg.flags <= isc_pkg::FLAGS_RESET;
      state_reg.enable <= isc_pkg::ENABLE_RESET;
      state_reg.prev_drop <= isc_pkg::DROP_RESET;
      state_reg.prev_timer <= isc_pkg::TIMER_RESET;
      state_reg.power <= isc_pkg::ISC_AWAKE;
      state_reg.master <= 1'b0;
      state_reg.irq <= 1'b0;
      state_reg.rdata <= isc_pkg::WORD_ZERO;
      state_reg.slverr <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    apb_rsp.pready = access_phase;
    apb_rsp.prdata = access_phase ? state_reg.rdata : isc_pkg::WORD_ZERO;
    apb_rsp.pslverr = access_phase & state_reg.slverr;
  end
  assign low_power = (state_reg.power == isc_pkg::ISC_ASLEEP);
  assign master_line = state_reg.master;
  assign irq_request = state_reg.irq;

  // ==========================================================
  // checks
  sequence s_sts_write;
    sts_wr;
  endsequence

  sequence s_bt_write;
    bt_wr;
  endsequence

  sequence s_asleep_no_wake;
    low_power && !bt_wr;
  endsequence

  a_set_beats_clear: assert property (@(posedge clk) disable iff (!rstn)
    (set_vec != isc_pkg::WORD_ZERO) |=>
      ((state_reg.flags & $past(set_vec & isc_pkg::STORED_MASK)) ==
       $past(set_vec & isc_pkg::STORED_MASK)))
    else $error("flag set lost");

  a_one_clears_flag: assert property (@(posedge clk) disable iff (!rstn)
    s_sts_write |=> ((state_reg.flags &
      $past(apb_req.pwdata & ~set_vec & isc_pkg::STORED_MASK)) == isc_pkg::WORD_ZERO))
    else $error("written one did not clear flag");

  a_zero_keeps_flag: assert property (@(posedge clk) disable iff (!rstn)
    s_sts_write |=> ((state_reg.flags &
      $past(state_reg.flags & ~apb_req.pwdata)) == $past(state_reg.flags & ~apb_req.pwdata)))
    else $error("written zero changed flag");

  a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rstn)
    access_phase && !apb_req.pwrite && (apb_req.paddr == isc_pkg::OFF_STS) |->
      ((apb_rsp.prdata & ~isc_pkg::IMPL_MASK) == isc_pkg::WORD_ZERO))
    else $error("reserved status bit read nonzero");

  a_phy_mirror_read: assert property (@(posedge clk) disable iff (!rstn)
    setup_phase && !apb_req.pwrite && (apb_req.paddr == isc_pkg::OFF_STS) ##1 access_phase
      |-> (apb_rsp.prdata[isc_pkg::B_PHY] == $past(evt.transceiver_event)))
    else $error("phy bit not live");

  a_drop_midpoint: assert property (@(posedge clk) disable iff (!rstn)
    ($past(evt.drop_count) == isc_pkg::DROP_BEFORE_MID) &&
    (evt.drop_count == isc_pkg::DROP_AFTER_MID) |=> state_reg.flags[isc_pkg::B_DROPMID])
    else $error("drop midpoint missed");

  a_timer_wrap_flag: assert property (@(posedge clk) disable iff (!rstn)
    ($past(evt.timer_count) == isc_pkg::TIMER_ZERO) &&
    (evt.timer_count == isc_pkg::TIMER_WRAP) |=> state_reg.flags[isc_pkg::B_TIMER])
    else $error("timer wrap missed");

  a_sw_event_flag: assert property (@(posedge clk) disable iff (!rstn)
    state_reg.enable[isc_pkg::B_SW] |=> state_reg.flags[isc_pkg::B_SW])
    else $error("software event not set");

  a_tx_stop_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.tx_stop_request && evt.tx_halted |=> state_reg.flags[isc_pkg::B_TXSTOP])
    else $error("tx stop not flagged");

  a_sleep_holds: assert property (@(posedge clk) disable iff (!rstn)
    s_asleep_no_wake |=> low_power)
    else $error("woke without byte test write");

  a_bt_write_wakes: assert property (@(posedge clk) disable iff (!rstn)
    s_bt_write |=> !low_power)
    else $error("byte test write did not wake");

  a_master_follows: assert property (@(posedge clk) disable iff (!rstn)
    (set_vec[isc_pkg::B_WAKE] && state_reg.enable[isc_pkg::B_WAKE]) |-> ##2 master_line)
    else $error("enabled flag did not raise master line");

  a_holdoff_wake_pass: assert property (@(posedge clk) disable iff (!rstn)
    hold_off_active && flag_view[isc_pkg::B_WAKE] && state_reg.enable[isc_pkg::B_WAKE]
      |=> irq_request)
    else $error("power event held off");

  a_holdoff_blocks: assert property (@(posedge clk) disable iff (!rstn)
    hold_off_active && ((active_vec & isc_pkg::WAKE_MASK) == isc_pkg::WORD_ZERO)
      |=> !irq_request)
    else $error("hold-off did not gate");

  a_unmapped_error: assert property (@(posedge clk) disable iff (!rstn)
    setup_phase && !mapped ##1 access_phase |-> apb_rsp.pslverr)
    else $error("unmapped access not refused");

  a_rx_halt_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.rx_halted |=> state_reg.flags[isc_pkg::B_RXSTOP])
    else $error("rx halt not flagged");

  a_tx_done_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.tx_buffer_complete |=> state_reg.flags[isc_pkg::B_TXDONE])
    else $error("tx buffer completion not flagged");

  a_rx_dma_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.rx_dma_done |=> state_reg.flags[isc_pkg::B_RXDMA])
    else $error("rx dma completion not flagged");

  a_wake_event_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.power_wake_event |=> state_reg.flags[isc_pkg::B_WAKE])
    else $error("power event not flagged");

  a_status_ovf_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.tx_status_overflow |=> state_reg.flags[isc_pkg::B_TXSOVF])
    else $error("status overflow not flagged");

  a_oversize_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.oversize_rx_frame |=> state_reg.flags[isc_pkg::B_OVERSIZE])
    else $error("oversize frame not flagged");

  a_rx_error_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.receive_error |=> state_reg.flags[isc_pkg::B_RXERR])
    else $error("receive error not flagged");

  a_tx_error_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.transmit_error |=> state_reg.flags[isc_pkg::B_TXERR])
    else $error("transmit error not flagged");

  a_data_overrun_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.tx_data_full && evt.tx_data_write |=> state_reg.flags[isc_pkg::B_TDOVR])
    else $error("data overrun not flagged");

  a_space_avail_flag: assert property (@(posedge clk) disable iff (!rstn)
    (evt.tx_free_blocks > evt.tx_avail_level) |=> state_reg.flags[isc_pkg::B_TDAVAIL])
    else $error("free space not flagged");

  a_tx_full_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.tx_status_full |=> state_reg.flags[isc_pkg::B_TSFULL])
    else $error("tx status full not flagged");

  a_rx_full_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.rx_status_full |=> state_reg.flags[isc_pkg::B_RSFULL])
    else $error("rx status full not flagged");

  a_tx_level_flag: assert property (@(posedge clk) disable iff (!rstn)
    (evt.tx_status_used > evt.tx_status_level) |=> state_reg.flags[isc_pkg::B_TSLEVEL])
    else $error("tx status level not flagged");

  a_rx_level_flag: assert property (@(posedge clk) disable iff (!rstn)
    (evt.rx_status_used > evt.rx_status_level) |=> state_reg.flags[isc_pkg::B_RSLEVEL])
    else $error("rx status level not flagged");

  a_frame_drop_flag: assert property (@(posedge clk) disable iff (!rstn)
    evt.frame_dropped |=> state_reg.flags[isc_pkg::B_RXDROP])
    else $error("dropped frame not flagged");

  a_pin_event_flags: assert property (@(posedge clk) disable iff (!rstn)
    (evt.pin_events != 3'h0) |=> ((state_reg.flags[isc_pkg::B_PIN_HI:isc_pkg::B_PIN_LO] &
      $past(evt.pin_events)) == $past(evt.pin_events)))
    else $error("pin event not flagged");

  a_latch_unmasked: assert property (@(posedge clk) disable iff (!rstn)
    evt.frame_dropped && !state_reg.enable[isc_pkg::B_RXDROP] |=>
      state_reg.flags[isc_pkg::B_RXDROP])
    else $error("masked event not latched");

  a_master_rises: assert property (@(posedge clk) disable iff (!rstn)
    (active_vec != isc_pkg::WORD_ZERO) |=> master_line)
    else $error("master line low with enabled flag");

  a_master_drops: assert property (@(posedge clk) disable iff (!rstn)
    (active_vec == isc_pkg::WORD_ZERO) |=> !master_line)
    else $error("master line high without enabled flag");

  a_irq_unheld: assert property (@(posedge clk) disable iff (!rstn)
    !hold_off_active |=> (irq_request == master_line))
    else $error("request differs from master line");

  a_read_data_held: assert property (@(posedge clk) disable iff (!rstn)
    setup_phase && !apb_req.pwrite && (apb_req.paddr == isc_pkg::OFF_STS) ##1 access_phase
      |-> (apb_rsp.prdata == $past(flag_view)))
    else $error("status read data not held");

  a_enable_write: assert property (@(posedge clk) disable iff (!rstn)
    en_wr |=> (state_reg.enable == $past(apb_req.pwdata & isc_pkg::IMPL_MASK)))
    else $error("enable mask write wrong");

  a_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
    !low_power && enter_low_power |=> low_power)
    else $error("low power not entered");

  a_power_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    sts_wr && apb_req.pwdata[isc_pkg::B_WAKE] && !evt.power_wake_event |=>
      !state_reg.flags[isc_pkg::B_WAKE])
    else $error("power flag not cleared");

endmodule

/* hw/isc_pkg.sv */
// constants, types and field layout of the interrupt status collector
package isc_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_STATE = 8'h54;
  localparam logic [7:0] OFF_STS = 8'h58;
  localparam logic [7:0] OFF_EN = 8'h5c;
  localparam logic [7:0] OFF_BT = 8'h64;
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;

  // ==========================================================
  // flag positions
  localparam int B_SW = 31;
  localparam int B_TXSTOP = 25;
  localparam int B_RXSTOP = 24;
  localparam int B_DROPMID = 23;
  localparam int B_TXDONE = 21;
  localparam int B_RXDMA = 20;
  localparam int B_TIMER = 19;
  localparam int B_PHY = 18;
  localparam int B_WAKE = 17;
  localparam int B_TXSOVF = 16;
  localparam int B_OVERSIZE = 15;
  localparam int B_RXERR = 14;
  localparam int B_TXERR = 13;
  localparam int B_TDOVR = 10;
  localparam int B_TDAVAIL = 9;
  localparam int B_TSFULL = 8;
  localparam int B_TSLEVEL = 7;
  localparam int B_RXDROP = 6;
  localparam int B_RSFULL = 4;
  localparam int B_RSLEVEL = 3;
  localparam int B_PIN_LO = 0;
  localparam int B_PIN_HI = 2;
  localparam int STATE_SLEEP_BIT = 0;
  localparam int STATE_MASTER_BIT = 12;

  // ==========================================================
  // masks and reset values
  localparam logic [31:0] IMPL_MASK = 32'h83bf_e7df;
  localparam logic [31:0] STORED_MASK = 32'h83bb_e7df;
  localparam logic [31:0] WAKE_MASK = 32'h0002_0000;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] DROP_BEFORE_MID = 32'h7fff_ffff;
  localparam logic [31:0] DROP_AFTER_MID = 32'h8000_0000;
  localparam logic [31:0] DROP_RESET = 32'h0000_0000;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;
  localparam logic [15:0] TIMER_WRAP = 16'hffff;
  localparam logic [15:0] TIMER_RESET = 16'hffff;

  // ==========================================================
  // types
  typedef enum logic [0:0] {
    ISC_AWAKE = 1'b0,
    ISC_ASLEEP = 1'b1
  } isc_power_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } isc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } isc_apb_rsp_t;

  typedef struct packed {
    logic tx_stop_request;
    logic tx_halted;
    logic rx_halted;
    logic [31:0] drop_count;
    logic tx_buffer_complete;
    logic rx_dma_done;
    logic [15:0] timer_count;
    logic transceiver_event;
    logic power_wake_event;
    logic tx_status_overflow;
    logic oversize_rx_frame;
    logic receive_error;
    logic transmit_error;
    logic tx_data_full;
    logic tx_data_write;
    logic [7:0] tx_free_blocks;
    logic [7:0] tx_avail_level;
    logic tx_status_full;
    logic [7:0] tx_status_used;
    logic [7:0] tx_status_level;
    logic frame_dropped;
    logic rx_status_full;
    logic [7:0] rx_status_used;
    logic [7:0] rx_status_level;
    logic [2:0] pin_events;
  } isc_evt_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enable;
    logic [31:0] prev_drop;
    logic [15:0] prev_timer;
    isc_power_t power;
    logic master;
    logic irq;
    logic [31:0] rdata;
    logic slverr;
  } isc_state_t;

endpackage

/* tb/isc_host_model.sv */
// apb master model standing in for the host processor
`timescale 1ns/1ps

module isc_host_model (
  input wire logic clk,
  output isc_pkg::isc_apb_req_t req,
  input wire isc_pkg::isc_apb_rsp_t rsp
);
  // ==========================================================
  // bus cycle
  initial begin
    req = '0;
  end

  // request held whole until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench of the interrupt status collector
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  logic clk;
  logic rstn;
  isc_pkg::isc_apb_req_t apb_req;
  isc_pkg::isc_apb_rsp_t apb_rsp;
  isc_pkg::isc_evt_t evt;
  logic hold_off_active;
  logic enter_low_power;
  logic low_power;
  logic master_line;
  logic irq_request;
  int fail_count;
  int comparisons;
  logic [31:0] rd;
  logic err;
  int bits[19] = '{25, 24, 23, 21, 20, 19, 17, 16, 15, 14, 13, 10, 9, 8, 7, 6, 4, 3, 2};
  int off;
  int b;

  isc_collector dut (.clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp), .evt(evt),
    .hold_off_active(hold_off_active), .enter_low_power(enter_low_power),
    .low_power(low_power), .master_line(master_line), .irq_request(irq_request));
  isc_host_model host (.clk(clk), .req(apb_req), .rsp(apb_rsp));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  function automatic isc_pkg::isc_evt_t idle_evt();
    idle_evt = '0;
    idle_evt.timer_count = isc_pkg::TIMER_RESET;
  endfunction

  task automatic rdreg(input logic [7:0] a);
    host.xfer(1'b0, a, isc_pkg::WORD_ZERO, rd, err);
  endtask

  task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q, err);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // two-step stimulus so counter crossings get their previous value
  task automatic pulse(input int k);
    isc_pkg::isc_evt_t pre;
    isc_pkg::isc_evt_t act;
    logic [7:0] lvl;
    pre = idle_evt();
    act = pre;
    lvl = 8'($urandom_range(0, 254));
    case (k)
      25: begin
        act.tx_stop_request = 1'b1;
        act.tx_halted = 1'b1;
      end
      24: act.rx_halted = 1'b1;
      23: begin
        pre.drop_count = isc_pkg::DROP_BEFORE_MID;
        act.drop_count = isc_pkg::DROP_AFTER_MID;
      end
      21: act.tx_buffer_complete = 1'b1;
      20: act.rx_dma_done = 1'b1;
      19: pre.timer_count = isc_pkg::TIMER_ZERO;
      17: act.power_wake_event = 1'b1;
      16: act.tx_status_overflow = 1'b1;
      15: act.oversize_rx_frame = 1'b1;
      14: act.receive_error = 1'b1;
      13: act.transmit_error = 1'b1;
      10: begin
        act.tx_data_full = 1'b1;
        act.tx_data_write = 1'b1;
      end
      9: begin
        act.tx_avail_level = lvl;
        act.tx_free_blocks = lvl + 8'h01;
      end
      8: act.tx_status_full = 1'b1;
      7: begin
        act.tx_status_level = lvl;
        act.tx_status_used = lvl + 8'h01;
      end
      6: act.frame_dropped = 1'b1;
      4: act.rx_status_full = 1'b1;
      3: begin
        act.rx_status_level = lvl;
        act.rx_status_used = lvl + 8'h01;
      end
      default: act.pin_events[k] = 1'b1;
    endcase
    @(posedge clk);
    evt <= pre;
    @(posedge clk);
    evt <= act;
    @(posedge clk);
    evt <= idle_evt();
  endtask

  task automatic final_report();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // tests
  initial begin
    rstn = 1'b0;
    evt = idle_evt();
    hold_off_active = 1'b0;
    enter_low_power = 1'b0;
    fail_count = 0;
    comparisons = 0;
    void'($urandom(89));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, isc_pkg::FLAGS_RESET)
    rdreg(isc_pkg::OFF_BT);
    `CHK(rd, isc_pkg::BYTE_TEST_VALUE)
    rdreg(8'h40);
    `CHK({err, rd}, {1'b1, isc_pkg::WORD_ZERO})
    wrreg(isc_pkg::OFF_EN, 32'hffff_ffff);
    rdreg(isc_pkg::OFF_EN);
    `CHK(rd, isc_pkg::IMPL_MASK)
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, 32'h8000_0000)
    wrreg(isc_pkg::OFF_STS, 32'h8000_0000);
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, 32'h8000_0000)
    @(negedge clk);
    `CHK(master_line, 1'b1)
    wrreg(isc_pkg::OFF_EN, isc_pkg::ENABLE_RESET);
    wrreg(isc_pkg::OFF_STS, 32'h8000_0000);
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, isc_pkg::WORD_ZERO)
    $display("test registers done");
    off = $urandom_range(0, 18);
    for (int i = 0; i < 21; i++) begin
      b = (i < 19) ? bits[(i + off) % 19] : i - 19;
      pulse(b);
      rdreg(isc_pkg::OFF_STS);
      `CHK(rd, 32'h1 << b)
      wrreg(isc_pkg::OFF_STS, ~(32'h1 << b));
      rdreg(isc_pkg::OFF_STS);
      `CHK(rd, 32'h1 << b)
      wrreg(isc_pkg::OFF_STS, 32'h1 << b);
      rdreg(isc_pkg::OFF_STS);
      `CHK(rd, isc_pkg::WORD_ZERO)
    end
    $display("test flags done");
    @(posedge clk);
    evt.transceiver_event <= 1'b1;
    settle(2);
    wrreg(isc_pkg::OFF_STS, 32'hffff_ffff);
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, 32'h0004_0000)
    evt.transceiver_event <= 1'b0;
    settle(2);
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, isc_pkg::WORD_ZERO)
    $display("test transceiver done");
    wrreg(isc_pkg::OFF_EN, 32'h0000_0040 | isc_pkg::WAKE_MASK);
    hold_off_active <= 1'b1;
    pulse(6);
    settle(2);
    `CHK({master_line, irq_request}, 2'b10)
    rdreg(isc_pkg::OFF_STATE);
    `CHK(rd[isc_pkg::STATE_MASTER_BIT], 1'b1)
    pulse(17);
    settle(2);
    `CHK(irq_request, 1'b1)
    wrreg(isc_pkg::OFF_STS, 32'h0002_0040);
    hold_off_active <= 1'b0;
    pulse(9);
    settle(2);
    `CHK(master_line, 1'b0)
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, 32'h0000_0200)
    wrreg(isc_pkg::OFF_STS, 32'h0000_0200);
    $display("test master line done");
    @(posedge clk);
    enter_low_power <= 1'b1;
    @(posedge clk);
    enter_low_power <= 1'b0;
    pulse(17);
    wrreg(isc_pkg::OFF_STS, isc_pkg::WAKE_MASK);
    settle(2);
    `CHK(low_power, 1'b1)
    rdreg(isc_pkg::OFF_STS);
    `CHK(rd, isc_pkg::WORD_ZERO)
    wrreg(isc_pkg::OFF_BT, $urandom());
    settle(2);
    `CHK(low_power, 1'b0)
    $display("test low power done");
    final_report();
  end
endmodule
